// ---- common/rst_seq_defines.svh ----
`ifndef RST_SEQ_DEFINES_SVH
`define RST_SEQ_DEFINES_SVH

// ----------------------------------------------------------------
// three-state pin codes (low, open, high)
// ----------------------------------------------------------------
`define SEL_LOW           2'h0
`define SEL_OPEN          2'h1
`define SEL_HIGH          2'h2

// ----------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------
`define CLK_HZ            20000000
`define MS_PER_S          1000
`define PRESS_MIN_MS      1
`define DIP_IGNORE_MS     2
`define T1_LOW_MS         10
`define T1_OPEN_MS        20
`define T1_HIGH_MS        50
`define MULT_OUT2         5
`define MULT_OUT3         10

// ----------------------------------------------------------------
// tolerance percentages
// ----------------------------------------------------------------
`define TOL_HIGH_PCT      5
`define TOL_LOW_PCT       10
`define TOL_OPEN_5V_PCT   15
`define TOL_OPEN_3V3_PCT  20

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define REL_RESET         3'h0
`define SEL_RESET         2'h0

`endif

// ---- common/rst_seq_pkg.sv ----
package rst_seq_pkg;

    // sequencer phase
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_COUNT,
        ST_DONE
    } seq_state_t;

    // two-bit code of a three-state strap pin
    typedef logic [1:0] sel_code_t;

endpackage

// ---- hdl/press_debouncer.sv ----
`timescale 1ns/1ps
`include "rst_seq_defines.svh"

// ----------------------------------------------------------------
// level debouncer: output follows input once stable for DEB_CYCLES
// ----------------------------------------------------------------
module press_debouncer
#(
    parameter int DEB_CYCLES = 20000
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // raw and filtered button level, low when pressed
    input  wire logic raw_n,
    output logic      level_n
);
    localparam int CW = $clog2(DEB_CYCLES + 1);

    logic [CW-1:0] cnt_r;
    logic          level_n_r;

    assign level_n = level_n_r;

    // count cycles of disagreement; any bounce back restarts the count
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_r <= '0;
        end
        else if (raw_n == level_n_r)
        begin
            cnt_r <= '0;
        end
        else if (cnt_r == CW'(DEB_CYCLES - 1))
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

    // flip only after a full stable window
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            level_n_r <= 1'b1;
        end
        else if (raw_n != level_n_r && cnt_r == CW'(DEB_CYCLES - 1))
        begin
            level_n_r <= raw_n;
        end
    end

    AST_DEB_WINDOW: assert property (
        @(posedge clk) disable iff (rst)
        $changed(level_n_r) |-> $past(cnt_r) == CW'(DEB_CYCLES - 1)
    ) else $error("debounced level changed before full window");

endmodule

// ---- hdl/reset_sequencer.sv ----
`timescale 1ns/1ps
`include "rst_seq_defines.svh"

// Contract
// - supply out of tolerance drives all three reset outputs low together.
// - on recovery, output 1 releases first, then output 2, then output 3.
// - released outputs stay high until a supply fault or manual reset.
// - at power-up all outputs held until supply good, then timed release.
// - tolerance select captured only below lowest trip, frozen above it.
// - tolerance pin high 5%, low 10%, open 15% or 20% by variant.
// - manual reset accepted while any reset output is inactive.
// - while an accepted press stays low, all outputs are forced low.
// - button release starts the same ordered timed release as recovery.
// - button input is debounced so bounce makes no spurious cycles.
// - delay select low, open or high picks one of three delay sets.
// - output 1 held at least 10, 20 or 50 ms for low, open, high.
// - all delays come from one clock through one divider chain.
// - output 2 delay is five times, output 3 ten times, output 1 delay.
// - supply dips shorter than 2 ms are ignored.
module reset_sequencer
    import rst_seq_pkg::*;
#(
    parameter int  MS_CYCLES   = `CLK_HZ / `MS_PER_S,
    parameter int  PRESS_CYC   = `PRESS_MIN_MS * (`CLK_HZ / `MS_PER_S),
    parameter int  DIP_CYC     = `DIP_IGNORE_MS * (`CLK_HZ / `MS_PER_S),
    parameter int  MS_W        = 10,
    parameter bit  VARIANT_3V3 = 1'b0
)
(
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    // supply comparator
    input  wire logic       POWER_GOOD,
    input  wire logic       SUPPLY_ABOVE_MIN,
    // straps, coded low / open / high
    input  wire sel_code_t  DELAY_SELECT,
    input  wire sel_code_t  TOLERANCE_SELECT,
    // pushbutton, low when pressed
    input  wire logic       MANUAL_RESET_N,
    // tolerance chosen for the comparator
    output logic [4:0]      TRIP_TOLERANCE_PCT,
    // sequenced resets, active low
    output logic            SEQ_RESET_OUT_1_N,
    output logic            SEQ_RESET_OUT_2_N,
    output logic            SEQ_RESET_OUT_3_N
);
    localparam int PW = $clog2(MS_CYCLES + 1);
    localparam int DW = $clog2(DIP_CYC + 1);

    // ------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------

    // first delay in ms for a delay strap code
    function automatic logic [MS_W-1:0] t1_ms(input sel_code_t s);
        logic [MS_W-1:0] v;
        v = MS_W'(`T1_OPEN_MS);
        unique case (s)
            `SEL_LOW:  v = MS_W'(`T1_LOW_MS);
            `SEL_HIGH: v = MS_W'(`T1_HIGH_MS);
            default:   v = MS_W'(`T1_OPEN_MS);
        endcase
        return v;
    endfunction

    // tolerance percentage for a tolerance strap code
    function automatic logic [4:0] tol_pct(input sel_code_t s);
        logic [4:0] v;
        v = VARIANT_3V3 ? 5'(`TOL_OPEN_3V3_PCT) : 5'(`TOL_OPEN_5V_PCT);
        unique case (s)
            `SEL_HIGH: v = 5'(`TOL_HIGH_PCT);
            `SEL_LOW:  v = 5'(`TOL_LOW_PCT);
            default:   v = VARIANT_3V3 ? 5'(`TOL_OPEN_3V3_PCT)
                                       : 5'(`TOL_OPEN_5V_PCT);
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    seq_state_t      state_r;
    seq_state_t      state_nxt;
    logic [PW-1:0]   pre_r;
    logic [MS_W-1:0] ms_r;
    logic [DW-1:0]   dip_r;
    logic            fail_r;
    logic            mr_hold_r;
    logic            press_n;
    logic            press_n_d_r;
    logic [2:0]      rel_r;
    logic [2:0]      rel_nxt;
    sel_code_t       dsel_r;
    sel_code_t       tol_r;
    logic            hold;
    logic            tick;
    logic [MS_W-1:0] lim1;
    logic [MS_W-1:0] lim2;
    logic [MS_W-1:0] lim3;

    assign hold = fail_r | mr_hold_r;
    assign tick = (pre_r == PW'(MS_CYCLES - 1));
    assign lim1 = t1_ms(dsel_r);
    assign lim2 = MS_W'(`MULT_OUT2) * lim1;
    assign lim3 = MS_W'(`MULT_OUT3) * lim1;

    // ------------------------------------------------------------
    // pushbutton
    // ------------------------------------------------------------

    // one-millisecond qualification window doubles as debounce
    press_debouncer
    #(
        .DEB_CYCLES (PRESS_CYC)
    )
    u_press
    (
        .clk        (CLK),
        .rst        (SYS_RST),
        .raw_n      (MANUAL_RESET_N),
        .level_n    (press_n)
    );

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            press_n_d_r <= 1'b1;
        end
        else
        begin
            press_n_d_r <= press_n;
        end
    end

    // a press counts only while some output is released
    // holding then keeps everything low until release
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            mr_hold_r <= 1'b0;
        end
        else if (!press_n && press_n_d_r && (|rel_r))
        begin
            mr_hold_r <= 1'b1;
        end
        else if (press_n)
        begin
            mr_hold_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // supply monitor
    // ------------------------------------------------------------

    // short dips are swallowed; a long one latches the fault
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            dip_r <= '0;
        end
        else if (POWER_GOOD)
        begin
            dip_r <= '0;
        end
        else if (dip_r != DW'(DIP_CYC - 1))
        begin
            dip_r <= dip_r + DW'(1);
        end
    end

    // fault assumed at reset so power-up starts held
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            fail_r <= 1'b1;
        end
        else if (!POWER_GOOD && dip_r == DW'(DIP_CYC - 1))
        begin
            fail_r <= 1'b1;
        end
        else if (POWER_GOOD)
        begin
            fail_r <= 1'b0;
        end
    end

    // tolerance strap is followed only below the lowest trip point
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            tol_r <= `SEL_RESET;
        end
        else if (!SUPPLY_ABOVE_MIN)
        begin
            tol_r <= TOLERANCE_SELECT;
        end
    end

    // registered so the comparator never sees a strap glitch
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            TRIP_TOLERANCE_PCT <= 5'h00;
        end
        else
        begin
            TRIP_TOLERANCE_PCT <= tol_pct(tol_r);
        end
    end

    // ------------------------------------------------------------
    // divider chain and sequence
    // ------------------------------------------------------------

    // delay strap is followed while held, frozen once counting
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            dsel_r <= `SEL_RESET;
        end
        else if (state_r == ST_HOLD)
        begin
            dsel_r <= DELAY_SELECT;
        end
    end

    // one prescaler feeds the ms counter for all three delays
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pre_r <= '0;
            ms_r  <= '0;
        end
        else if (hold || state_r != ST_COUNT)
        begin
            pre_r <= '0;
            ms_r  <= '0;
        end
        else if (tick)
        begin
            pre_r <= '0;
            ms_r  <= ms_r + MS_W'(1);
        end
        else
        begin
            pre_r <= pre_r + PW'(1);
        end
    end

    // phase control
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_HOLD:  if (!hold) state_nxt = ST_COUNT;
            ST_COUNT: if (hold) state_nxt = ST_HOLD;
                      else if (ms_r >= lim3) state_nxt = ST_DONE;
            ST_DONE:  if (hold) state_nxt = ST_HOLD;
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state_r <= ST_HOLD;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // each output releases when its own multiple is reached
    always_comb
    begin
        rel_nxt = rel_r;
        if (hold)
        begin
            rel_nxt = `REL_RESET;
        end
        else if (state_r == ST_COUNT)
        begin
            rel_nxt[0] = (ms_r >= lim1);
            rel_nxt[1] = (ms_r >= lim2);
            rel_nxt[2] = (ms_r >= lim3);
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rel_r <= `REL_RESET;
        end
        else
        begin
            rel_r <= rel_nxt;
        end
    end

    // gated by hold so a fault pulls every line the same cycle
    assign SEQ_RESET_OUT_1_N = rel_r[0] & ~hold;
    assign SEQ_RESET_OUT_2_N = rel_r[1] & ~hold;
    assign SEQ_RESET_OUT_3_N = rel_r[2] & ~hold;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_FAIL_ALL_LOW: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        fail_r |-> (!SEQ_RESET_OUT_1_N && !SEQ_RESET_OUT_2_N
                   && !SEQ_RESET_OUT_3_N) ##1 (rel_r == `REL_RESET)
    ) else $error("output high during supply fault");

    AST_ORDER: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        (SEQ_RESET_OUT_2_N |-> SEQ_RESET_OUT_1_N)
        and (SEQ_RESET_OUT_3_N |-> SEQ_RESET_OUT_2_N)
    ) else $error("outputs released out of order");

    AST_STAY_HIGH: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        $fell(SEQ_RESET_OUT_3_N) |-> hold
    ) else $error("released output fell without cause");

    AST_HOLD_LOW: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        state_r == ST_HOLD |-> !SEQ_RESET_OUT_1_N
    ) else $error("output released while held");

    AST_TOL_FROZEN: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        SUPPLY_ABOVE_MIN && $past(SUPPLY_ABOVE_MIN) |-> $stable(tol_r)
    ) else $error("tolerance changed above trip point");

    AST_MR_FORCE: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        mr_hold_r && !press_n |=> !SEQ_RESET_OUT_1_N
    ) else $error("output high while button held");

    AST_MR_RESTART: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        $fell(mr_hold_r) && !fail_r |=> state_r == ST_COUNT && ms_r == 0
    ) else $error("release did not restart sequence");

    AST_T1_TIME: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        $rose(SEQ_RESET_OUT_1_N) |-> ms_r == lim1
    ) else $error("output 1 released at wrong time");

    AST_T2_TIME: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        $rose(SEQ_RESET_OUT_2_N) |-> ms_r == MS_W'(`MULT_OUT2) * lim1
    ) else $error("output 2 released at wrong time");

    AST_DIP_FILTER: assert property (
        @(posedge CLK) disable iff (SYS_RST)
        $rose(fail_r) |-> $past(dip_r) == DW'(DIP_CYC - 1)
    ) else $error("fault raised before dip window");

endmodule

// ---- sim/button_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// pushbutton with contact chatter and a pull-up on the pin
// ----------------------------------------------------------------
module button_model
#(
    parameter int BOUNCE = 3
)
(
    // clock
    input  wire logic clk,
    // operator holds the button while press is high
    input  wire logic press,
    // pin to the sequencer, low when pressed
    output logic      button_n
);
    logic press_d;
    int   chatter;

    // idle level is high: the pin is pulled up when nobody presses
    initial
    begin
        press_d  = 1'b0;
        chatter  = 0;
        button_n = 1'b1;
    end

    // every change of the contact chatters before it settles
    always @(posedge clk)
    begin
        if (press != press_d)
            chatter <= BOUNCE;
        else if (chatter > 0)
            chatter <= chatter - 1;
        press_d <= press;
        if (chatter > 0)
            button_n <= ~button_n; // bounce, shorter than the filter
        else
            button_n <= ~press_d;
    end
endmodule

// ---- sim/reset_sequencer_test.sv ----
`timescale 1ns/1ps
`include "rst_seq_defines.svh"

module reset_sequencer_test
    import rst_seq_pkg::*;
;
    // ------------------------------------------------------------
    // shortened counts so that the longest delay set fits the run
    // ------------------------------------------------------------
    localparam int MS    = 4;
    localparam int PRS   = 5;
    localparam int DIP   = 8;
    localparam int BNC   = 3;
    localparam int SLACK = 8;

    logic      clk;
    logic      sys_rst;
    logic      power_good;
    logic      above_min;
    logic      press;
    logic      button_n;
    sel_code_t delay_sel;
    sel_code_t tol_sel;
    logic [4:0] tol_pct;
    logic      out1_n;
    logic      out2_n;
    logic      out3_n;
    sel_code_t s_tol_sel;
    logic [4:0] s_tol_pct;
    logic      s_out1_n;
    logic      s_out2_n;
    logic      s_out3_n;
    int        err_count;
    int        num_checks;
    int        cycles;
    integer    seed;

    reset_sequencer #(.MS_CYCLES(MS), .PRESS_CYC(PRS), .DIP_CYC(DIP))
    reset_sequencer_inst (
        .CLK(clk), .SYS_RST(sys_rst), .POWER_GOOD(power_good),
        .SUPPLY_ABOVE_MIN(above_min), .DELAY_SELECT(delay_sel),
        .TOLERANCE_SELECT(tol_sel), .MANUAL_RESET_N(button_n),
        .TRIP_TOLERANCE_PCT(tol_pct), .SEQ_RESET_OUT_1_N(out1_n),
        .SEQ_RESET_OUT_2_N(out2_n), .SEQ_RESET_OUT_3_N(out3_n));

    button_model #(.BOUNCE(BNC)) button_model_inst (
        .clk(clk), .press(press), .button_n(button_n));

    // cascaded slave: its button pin hangs on the master's last output
    reset_sequencer #(.MS_CYCLES(MS), .PRESS_CYC(PRS), .DIP_CYC(DIP))
    slave_reset_sequencer_inst (
        .CLK(clk), .SYS_RST(sys_rst), .POWER_GOOD(power_good),
        .SUPPLY_ABOVE_MIN(above_min), .DELAY_SELECT(delay_sel),
        .TOLERANCE_SELECT(s_tol_sel), .MANUAL_RESET_N(out3_n),
        .TRIP_TOLERANCE_PCT(s_tol_pct), .SEQ_RESET_OUT_1_N(s_out1_n),
        .SEQ_RESET_OUT_2_N(s_out2_n), .SEQ_RESET_OUT_3_N(s_out3_n));

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // the whole run needs under 8000 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_count++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // expectations and comparisons
    // ------------------------------------------------------------
    function automatic int lim_ms(input sel_code_t c);
        if (c === `SEL_LOW)
            return `T1_LOW_MS;
        if (c === `SEL_HIGH)
            return `T1_HIGH_MS;
        return `T1_OPEN_MS; // code 3 reads as open
    endfunction

    function automatic logic [4:0] exp_tol(input sel_code_t c);
        if (c === `SEL_LOW)
            return 5'(`TOL_LOW_PCT);
        if (c === `SEL_HIGH)
            return 5'(`TOL_HIGH_PCT);
        return 5'(`TOL_OPEN_5V_PCT);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // a count must land no earlier than lo and only a little later
    task automatic win(input int t, input int lo);
        num_checks++;
        if (t < lo || t > lo + SLACK)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, t, lo);
        end
    endtask

    task automatic outs_for(input int n, input logic [2:0] exp);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            check({out1_n, out2_n, out3_n}, exp);
        end
    endtask

    // timing counted from the edge that changed the cause
    task automatic wait_release(input sel_code_t sel, input int off);
        int t1;
        int t2;
        int t3;
        int n;
        int l;
        t1 = 0;
        t2 = 0;
        t3 = 0;
        n = 0;
        l = lim_ms(sel) * MS;
        while (t3 == 0 && n < off + 10 * l + 40)
        begin
            @(posedge clk);
            #1;
            n++;
            if (out1_n === 1'b1 && t1 == 0)
                t1 = n;
            if (out2_n === 1'b1 && t2 == 0)
                t2 = n;
            if (out3_n === 1'b1 && t3 == 0)
                t3 = n;
        end
        win(t1, off + l);
        win(t2, off + `MULT_OUT2 * l);
        win(t3, off + `MULT_OUT3 * l);
    endtask

    task automatic power_fail();
        int n;
        n = 0;
        @(posedge clk);
        power_good <= 1'b0;
        while (out1_n !== 1'b0 && n < DIP + 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        win(n, DIP);
        check({out1_n, out2_n, out3_n}, 3'h0);
    endtask

    task automatic recover(input sel_code_t sel);
        @(posedge clk);
        delay_sel  <= sel;
        power_good <= 1'b1;
        wait_release(sel, 0);
    endtask

    task automatic complete_run();
        if (err_count == 0 && num_checks > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        sel_code_t codes[4];
        int n;
        seed = 32'h4407_f4b1;
        codes = '{`SEL_LOW, `SEL_OPEN, `SEL_HIGH, `SEL_LOW};
        codes[3] = sel_code_t'($random(seed));
        sys_rst = 1'b1;
        power_good = 1'b0;
        above_min = 1'b0;
        press = 1'b0;
        delay_sel = `SEL_LOW;
        tol_sel = `SEL_LOW;
        s_tol_sel = `SEL_OPEN; // slave trips lower than the master
        err_count = 0;
        num_checks = 0;
        cycles = 0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        // strap follows the pin while the supply is still low
        for (int c = 0; c < 4; c++)
        begin
            @(posedge clk);
            tol_sel <= sel_code_t'(c ^ 1);
            repeat (3) @(posedge clk);
            #1;
            check(tol_pct, exp_tol(sel_code_t'(c ^ 1)));
        end
        @(posedge clk);
        above_min <= 1'b1;
        tol_sel <= `SEL_LOW;
        outs_for(4, 3'h0);
        check(tol_pct, exp_tol(`SEL_HIGH));
        check(s_tol_pct, exp_tol(`SEL_OPEN));
        recover(`SEL_LOW);
        outs_for(20, 3'h7);
        // a dip shorter than the filter leaves the outputs alone
        @(posedge clk);
        power_good <= 1'b0;
        repeat (2 + ($random(seed) & 3)) @(posedge clk);
        power_good <= 1'b1;
        outs_for(2 * DIP, 3'h7);
        foreach (codes[i])
        begin
            power_fail();
            recover(codes[i]);
        end
        // fault after the first output has gone
        power_fail();
        @(posedge clk);
        power_good <= 1'b1;
        n = 0;
        while (out1_n !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        power_fail();
        recover(`SEL_OPEN);
        // a tap shorter than the filter, chatter included
        @(posedge clk);
        press <= 1'b1;
        @(posedge clk);
        press <= 1'b0;
        outs_for(4 * PRS, 3'h7);
        // a held press forces all outputs until let go
        @(posedge clk);
        press <= 1'b1;
        n = 0;
        while (out1_n !== 1'b0 && n < PRS + BNC + 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        win(n, PRS);
        outs_for(6 * PRS, 3'h0);
        @(posedge clk);
        press <= 1'b0;
        wait_release(`SEL_OPEN, PRS + BNC);
        // master's last output let go: the slave now runs its own release
        check({s_out1_n, s_out2_n, s_out3_n}, 3'h0);
        n = 0;
        while (s_out1_n !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        win(n, PRS + lim_ms(`SEL_OPEN) * MS);
        complete_run();
    end
endmodule
